// ==== pkg/hrs_regs.vh ====
// Register map and constants of the hardware return stack
`ifndef HRS_REGS_VH
`define HRS_REGS_VH

// Core-side register offsets
`define HRS_PTR_OFS       8'hdf
`define HRS_SLOT_BASE     8'hf0
`define HRS_SLOT_MASK     8'hf0
// Own registers: interrupt status and mask
`define HRS_IRQ_STAT_OFS  8'he0
`define HRS_IRQ_MASK_OFS  8'he1

// Pointer register fields
`define HRS_GIE_BIT       7
`define HRS_PTR_RST       3'h7
`define HRS_GIE_RST       1'h0
`define HRS_SLOT_RST      11'h000
`define HRS_PTR_WRAP      3'h0

// Avalon response codes
`define HRS_RESP_OK       2'h0
`define HRS_RESP_UNMAPPED 2'h2

// Event bits: 0 overflow, 1 underflow
`define HRS_EV_OVF        0
`define HRS_EV_UNF        1
`define HRS_EV_W          2

`endif

// ==== logic/hrs_slot_bank.v ====
// Eight-slot storage of saved program counter values
`timescale 1ns/1ps
`default_nettype none
`include "hrs_regs.vh"

module hrs_slot_bank #(
  parameter DEPTH = 8,
  parameter AW    = 3,
  parameter DW    = 11
) (
  input  wire          core_clk,
  input  wire          rst,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_idx,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_idx,
  output wire [DW-1:0] rd_data
);

  reg [DW-1:0] slot_q [0:DEPTH-1];
  integer i;

  assign rd_data = slot_q[rd_idx];

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        slot_q[i] <= `HRS_SLOT_RST;
      end
    end else if (wr_en) begin
      slot_q[wr_idx] <= wr_data;
    end
  end

endmodule // hrs_slot_bank
`default_nettype wire

// ==== logic/hrs_irq_unit.v ====
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "hrs_regs.vh"

module hrs_irq_unit #(
  parameter W = 2
) (
  input  wire         core_clk,
  input  wire         rst,
  input  wire [W-1:0] event_pulse,
  input  wire         stat_wr,
  input  wire         mask_wr,
  input  wire [W-1:0] wdata,
  output reg  [W-1:0] stat_q,
  output reg  [W-1:0] mask_q,
  output reg          irq_q
);

  wire [W-1:0] stat_d;

  // Set wins over a write-one clear
  assign stat_d = (stat_q & ~(stat_wr ? wdata : {W{1'b0}})) | event_pulse;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_q <= {W{1'b0}};
      mask_q <= {W{1'b0}};
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (mask_wr) begin
        mask_q <= wdata;
      end
      irq_q <= |(stat_d & (mask_wr ? wdata : mask_q));
    end
  end

endmodule // hrs_irq_unit
`default_nettype wire

// ==== logic/hrs_return_stack.v ====
// Hardware return-address stack with Avalon-MM register access
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "hrs_regs.vh"

module hrs_return_stack #(
  parameter DEPTH = 8,
  parameter PW    = 3,
  parameter CW    = 11
) (
  input  wire          core_clk,
  input  wire          rst,
  // Core sequencer side
  input  wire          call_push,
  input  wire          irq_entry_push,
  input  wire          subroutine_return_op,
  input  wire          irq_return_op,
  input  wire [CW-1:0] push_counter,
  output reg  [CW-1:0] pop_counter_q,
  output reg           pop_valid_q,
  output reg           global_irq_enable_q,
  output reg  [PW-1:0] stack_level_pointer_q,
  output reg           irq_q,
  // Avalon-MM slave
  input  wire [7:0]    avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  input  wire [3:0]    avs_byteenable,
  output reg  [31:0]   avs_readdata,
  output reg           avs_waitrequest,
  output reg  [1:0]    avs_response
);

  ////////////////////////////////////////////////////////////////////
  // Slot index from a pointer value
  function [PW-1:0] slot_of;
    input [PW-1:0] ptr;
    begin
      slot_of = ~ptr;
    end
  endfunction

  function is_slot_addr;
    input [7:0] a;
    begin
      is_slot_addr = ((a & `HRS_SLOT_MASK) == `HRS_SLOT_BASE);
    end
  endfunction

  // Pointer one level deeper; wraps past zero to 111, flagged as an overflow event
  function [PW-1:0] ptr_push;
    input [PW-1:0] ptr;
    begin
      ptr_push = ptr - {{(PW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Pointer one level shallower
  function [PW-1:0] ptr_pop;
    input [PW-1:0] ptr;
    begin
      ptr_pop = ptr + {{(PW-1){1'b0}}, 1'b1};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Bus decode; one wait state, answer on second cycle
  reg           ack_q;
  wire          acc;
  wire          bus_go;
  wire          wr_fire;
  wire          lane0;
  wire [7:0]    wbyte;
  wire          hit_ptr;
  wire          hit_slot;
  wire          hit_stat;
  wire          hit_mask;
  wire          mapped;
  wire [PW-1:0] bus_slot;
  wire          bus_low;
  wire          ptr_wr;
  wire          stat_wr;
  wire          mask_wr;
  wire          slot_wr;

  assign acc      = avs_read | avs_write;
  // Taken only while idle, so a held request is served once
  assign bus_go   = acc & avs_waitrequest & ~ack_q;
  // Writes act at the edge where waitrequest is seen low
  assign wr_fire  = avs_write & ack_q;
  assign lane0    = avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];
  assign hit_ptr  = (avs_address == `HRS_PTR_OFS);
  assign hit_slot = is_slot_addr(avs_address);
  assign hit_stat = (avs_address == `HRS_IRQ_STAT_OFS);
  assign hit_mask = (avs_address == `HRS_IRQ_MASK_OFS);
  assign mapped   = hit_ptr | hit_slot | hit_stat | hit_mask;
  // Slot n high at 0xf0+2n, low at 0xf1+2n
  assign bus_slot = avs_address[3:1];
  assign bus_low  = avs_address[0];
  // Every register sits in lane 0; upper lanes are ignored
  assign ptr_wr   = wr_fire & hit_ptr & lane0;
  assign stat_wr  = wr_fire & hit_stat & lane0;
  assign mask_wr  = wr_fire & hit_mask & lane0;
  assign slot_wr  = wr_fire & hit_slot & lane0;

  ////////////////////////////////////////////////////////////////////
  // Stack push and pop
  wire          do_push;
  wire          do_pop;
  wire          push_only;
  wire          pop_only;
  reg  [PW-1:0] ptr_d;
  wire [PW-1:0] top_slot;
  wire [CW-1:0] rd_data;
  wire [CW-1:0] bus_rd_data;
  reg  [CW-1:0] sw_data;
  reg  [CW-1:0] bank_wdata;
  reg  [PW-1:0] bank_widx;
  reg           bank_we;

  assign do_push   = call_push | irq_entry_push;
  assign do_pop    = subroutine_return_op | irq_return_op;
  // Push and pop together leave the stack as it was
  assign push_only = do_push & ~do_pop;
  assign pop_only  = do_pop & ~do_push;
  assign top_slot  = slot_of(ptr_pop(stack_level_pointer_q));

  always @* begin
    ptr_d = stack_level_pointer_q;
    if (push_only) begin
      ptr_d = ptr_push(stack_level_pointer_q);
    end else if (pop_only) begin
      ptr_d = ptr_pop(stack_level_pointer_q);
    end
    // Software write loses to a same-cycle push or pop
    if (ptr_wr && !do_push && !do_pop) begin
      ptr_d = wbyte[PW-1:0];
    end
  end

  // counter kept as two halves
  // Bus write to a slot half merges into the held value
  always @* begin
    sw_data = bus_rd_data;
    if (bus_low) begin
      sw_data[7:0] = wbyte;
    end else begin
      sw_data[CW-1:8] = wbyte[CW-9:0];
    end
  end

  // One write port: a push outranks a software slot write
  always @* begin
    if (push_only) begin
      bank_we    = 1'b1;
      bank_wdata = push_counter;
      bank_widx  = slot_of(stack_level_pointer_q);
    end else begin
      bank_we    = slot_wr;
      bank_wdata = sw_data;
      bank_widx  = bus_slot;
    end
  end

  hrs_slot_bank #(
    .DEPTH (DEPTH),
    .AW    (PW),
    .DW    (CW)
  ) u_bank (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (bank_we),
    .wr_idx   (bank_widx),
    .wr_data  (bank_wdata),
    .rd_idx   (top_slot),
    .rd_data  (rd_data)
  );

  // Second read port for the bus; slots are small
  hrs_slot_bank #(
    .DEPTH (DEPTH),
    .AW    (PW),
    .DW    (CW)
  ) u_shadow (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (bank_we),
    .wr_idx   (bank_widx),
    .wr_data  (bank_wdata),
    .rd_idx   (bus_slot),
    .rd_data  (bus_rd_data)
  );

  ////////////////////////////////////////////////////////////////////
  // Underflow and overflow events
  reg  [`HRS_EV_W-1:0] ev;
  wire [`HRS_EV_W-1:0] stat;
  wire [`HRS_EV_W-1:0] mask;
  wire                 irq_w;

  // Pointer alone cannot tell full from empty; flag the wrap edges
  always @* begin
    ev = {`HRS_EV_W{1'b0}};
    // Push that turns the pointer from 000 round to 111
    ev[`HRS_EV_OVF] = push_only & (stack_level_pointer_q == `HRS_PTR_WRAP);
    // Pop taken at the reset level
    ev[`HRS_EV_UNF] = pop_only & (stack_level_pointer_q == `HRS_PTR_RST);
  end

  hrs_irq_unit #(
    .W (`HRS_EV_W)
  ) u_irq (
    .core_clk    (core_clk),
    .rst         (rst),
    .event_pulse (ev),
    .stat_wr     (stat_wr),
    .mask_wr     (mask_wr),
    .wdata       (wbyte[`HRS_EV_W-1:0]),
    .stat_q      (stat),
    .mask_q      (mask),
    .irq_q       (irq_w)
  );

  ////////////////////////////////////////////////////////////////////
  // Read mux; unused bits read as zero
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0;
    case (1'b1)
      hit_ptr: begin
        rdata_d[`HRS_GIE_BIT] = global_irq_enable_q;
        rdata_d[PW-1:0]       = stack_level_pointer_q;
      end
      hit_slot: begin
        if (bus_low) begin
          rdata_d[7:0] = bus_rd_data[7:0];
        end else begin
          rdata_d[CW-9:0] = bus_rd_data[CW-1:8];
        end
      end
      hit_stat: begin
        rdata_d[`HRS_EV_W-1:0] = stat;
      end
      hit_mask: begin
        rdata_d[`HRS_EV_W-1:0] = mask;
      end
      default: begin
        rdata_d = 32'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Pointer and interrupt enable
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_level_pointer_q <= `HRS_PTR_RST;
      global_irq_enable_q   <= `HRS_GIE_RST;
    end else begin
      stack_level_pointer_q <= ptr_d;
      if (ptr_wr) begin
        global_irq_enable_q <= wbyte[`HRS_GIE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Popped counter towards the sequencer
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pop_counter_q <= `HRS_SLOT_RST;
      pop_valid_q   <= 1'b0;
    end else begin
      pop_valid_q <= pop_only;
      if (pop_only) begin
        pop_counter_q <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt line; retimed so the port is a flop of this module
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_w;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus answer; waitrequest drops one cycle after the request
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      avs_response    <= `HRS_RESP_OK;
    end else begin
      ack_q           <= bus_go;
      avs_waitrequest <= ~bus_go;
      if (bus_go) begin
        avs_readdata <= avs_read ? rdata_d : 32'h0;
        avs_response <= mapped ? `HRS_RESP_OK : `HRS_RESP_UNMAPPED;
      end
    end
  end

endmodule // hrs_return_stack
`default_nettype wire

// ==== bench/hrs_sva.sv ====
// Port checker of the return stack
`timescale 1ns/1ps
`default_nettype none
module hrs_sva (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        call_push,
  input wire logic        irq_entry_push,
  input wire logic        subroutine_return_op,
  input wire logic        irq_return_op,
  input wire logic [10:0] push_counter,
  input wire logic [10:0] pop_counter_q,
  input wire logic        pop_valid_q,
  input wire logic        global_irq_enable_q,
  input wire logic [2:0]  stack_level_pointer_q,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response
);
  wire logic psh = call_push | irq_entry_push;
  wire logic pop = subroutine_return_op | irq_return_op;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  push_dec_a: assert property (psh && !pop |=>
    stack_level_pointer_q == $past(stack_level_pointer_q) - 3'h1) else $error("push step");
  pop_inc_a: assert property (pop && !psh |=>
    stack_level_pointer_q == $past(stack_level_pointer_q) + 3'h1) else $error("pop step");
  pop_valid_a: assert property (pop && !psh |=> pop_valid_q) else $error("no pop");
  pop_quiet_a: assert property (!(pop && !psh) |=> !pop_valid_q) else $error("stray pop");
  lifo_order_a: assert property (psh && !pop && !avs_write ##1 pop && !psh && !avs_write
    |=> pop_counter_q == $past(push_counter, 2)) else $error("pop value");
  gie_write_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'hdf
    && avs_byteenable[0] |=> global_irq_enable_q == $past(avs_writedata[7])) else $error("gie");
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait state");
  unmapped_rd_a: assert property (avs_read && avs_waitrequest && avs_address < 8'hdf
    |=> avs_response == 2'h2 && avs_readdata == 32'h0) else $error("unmapped read");
  high_part_a: assert property (avs_read && avs_waitrequest && avs_address[7:4] == 4'hf
    && !avs_address[0] |=> avs_readdata[31:3] == 29'h0) else $error("high part");
endmodule // hrs_sva
bind hrs_return_stack hrs_sva hrs_sva_i (.*);
`default_nettype wire

// ==== bench/hrs_core_model.sv ====
// Core sequencer model: calls, interrupt entries, returns
`timescale 1ns/1ps
`default_nettype none
module hrs_core_model (
  input  wire logic        core_clk,
  output var  logic        call_push,
  output var  logic        irq_entry_push,
  output var  logic        subroutine_return_op,
  output var  logic        irq_return_op,
  output var  logic [10:0] push_counter
);
  initial begin
    {irq_return_op, subroutine_return_op, irq_entry_push, call_push} = 4'h0;
    push_counter = 11'h0;
  end
  task automatic op(input logic [3:0] m, input logic [10:0] pc);
    @(posedge core_clk);
    {irq_return_op, subroutine_return_op, irq_entry_push, call_push} <= m;
    // Released counter toggles, never left stale
    push_counter <= (m[1:0] != 2'h0) ? pc : ~push_counter;
  endtask
endmodule // hrs_core_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench of the return stack
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk, rst, call_push, irq_entry_push, subroutine_return_op, irq_return_op;
  logic        pop_valid_q, global_irq_enable_q, irq_q, avs_read, avs_write, avs_waitrequest;
  logic [10:0] push_counter, pop_counter_q, pc;
  logic [10:0] sh [8];
  logic [2:0]  stack_level_pointer_q, p;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response;
  logic [33:0] exp_rd [$];
  logic [10:0] exp_pop [$];
  int          fails, checks_done, seed, i;
  hrs_core_model hrs_core_model_i (.*);
  hrs_return_stack hrs_return_stack_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge core_clk) begin
    if (pop_valid_q === 1'b1) begin
      chk("pop", exp_pop.size() ? exp_pop.pop_front() : 'x, pop_counter_q);
    end
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk("rdata", exp_rd.size() ? exp_rd.pop_front() : 'x, {avs_response, avs_readdata});
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    {avs_write, avs_read, avs_address, avs_writedata, avs_byteenable} <= {w, !w, a, d, be};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      fails++;
      report_and_stop;
    end
    {avs_write, avs_read} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic so(input logic [3:0] m, input logic [10:0] v);
    if (m[1:0] != 2'h0 && m[3:2] == 2'h0) begin
      sh[~p] = v;
      p = p - 3'h1;
    end
    if (m[3:2] != 2'h0 && m[1:0] == 2'h0) begin
      exp_pop.push_back(sh[~(p + 3'h1)]);
      p = p + 3'h1;
    end
    hrs_core_model_i.op(m, v);
  endtask
  task automatic step(input logic [3:0] m, input logic [10:0] v);
    so(m, v);
    hrs_core_model_i.op(4'h0, 11'h0);
    @(negedge core_clk);
    chk("pointer", p, stack_level_pointer_q);
  endtask
  initial begin
    {seed, fails, checks_done, p, rst} = {32'd98, 64'd0, 3'h7, 1'b1};
    {avs_write, avs_read, avs_address, avs_writedata, avs_byteenable} = '0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'hdf, 34'h07);
    rd(8'hf0, 34'h0);
    bus(1'b1, 8'hdf, 32'h07, 4'h1);
    for (i = 0; i < 9; i++) begin
      pc = 11'($random(seed));
      step(i[0] ? 4'h2 : 4'h1, pc);
    end
    for (i = 0; i < 8; i++) begin
      rd(8'(8'hf0 + 2 * i), {31'h0, sh[i][10:8]});
      rd(8'(8'hf1 + 2 * i), {26'h0, sh[i][7:0]});
    end
    so(4'h1, 11'($random(seed)));
    so(4'h4, 11'h0);
    step(4'h5, 11'h2aa);
    for (i = 0; i < 9; i++) step(i[0] ? 4'h8 : 4'h4, 11'h0);
    rd(8'he0, 34'h3);
    chk("irq", 1'b0, irq_q);
    bus(1'b1, 8'he1, 32'h1, 4'h1);
    repeat (2) @(negedge core_clk);
    chk("irq", 1'b1, irq_q);
    bus(1'b1, 8'he0, 32'h1, 4'h1);
    repeat (2) @(negedge core_clk);
    chk("irq", 1'b0, irq_q);
    rd(8'he0, 34'h2);
    bus(1'b1, 8'hdf, 32'h87, 4'h1);
    bus(1'b1, 8'hdf, 32'h0, 4'h0);
    @(negedge core_clk);
    chk("gie", 1'b1, global_irq_enable_q);
    rd(8'hdf, 34'h87);
    bus(1'b1, 8'hf1, 32'ha5, 4'h1);
    bus(1'b1, 8'hf0, 32'hff, 4'h1);
    rd(8'hf1, 34'ha5);
    rd(8'hf0, 34'h7);
    bus(1'b1, 8'h10, 32'hff, 4'h1);
    rd(8'h10, {2'h2, 32'h0});
    repeat (3) @(negedge core_clk);
    chk("queues", 34'h0, 34'(exp_pop.size() + exp_rd.size()));
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
